/* File: rtl/rtop_serial_port.sv */
// Return-to-one single-wire serial port, device end.
// Assumes an external pull-up on the pin and a register file that
// answers a read select within the stop hold time.
`timescale 1ns/1ns
module rtop_serial_port
  import rtop_pkg::*;
#(
  parameter logic [CNT_W-1:0] P_BIT_CYCLE = CNT_W'(BIT_CYCLE_CYC),
  parameter logic [CNT_W-1:0] P_START_LOW = CNT_W'(START_LOW_CYC),
  parameter logic [CNT_W-1:0] P_DATA_SETUP = CNT_W'(DATA_SETUP_CYC),
  parameter logic [CNT_W-1:0] P_DATA_HOLD = CNT_W'(DATA_HOLD_CYC),
  parameter logic [CNT_W-1:0] P_STOP_HOLD = CNT_W'(STOP_HOLD_CYC),
  parameter logic [CNT_W-1:0] P_BREAK_LOW = CNT_W'(BREAK_LOW_CYC),
  parameter logic [CNT_W-1:0] P_BREAK_RECOVERY =
    CNT_W'(BREAK_RECOVERY_CYC)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Serial data pin, open drain
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe_n,
  // Register file access
  output rtop_reg_req_s reg_req,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Status
  output logic [DATA_W-1:0] command_byte_register,
  output logic break_seen
);

  // ---------------------------------------------------------------
  // Pin synchroniser and filtered level
  // ---------------------------------------------------------------
  logic dq_s1_r;
  logic dq_s2_r;
  logic dq_s3_r;
  logic line_r;
  logic line_q_r;
  logic rise;
  logic fall;

  // Level changes only once the last two stages agree
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dq_s1_r <= 1'h1;
      dq_s2_r <= 1'h1;
      dq_s3_r <= 1'h1;
      line_r <= 1'h1;
      line_q_r <= 1'h1;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
      if (dq_s2_r == dq_s3_r) begin
        line_r <= dq_s3_r;
      end
      line_q_r <= line_r;
    end
  end

  assign rise = line_r & ~line_q_r;
  assign fall = ~line_r & line_q_r;

  // ---------------------------------------------------------------
  // Low pulse timer
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] low_cnt_r;
  logic drv_r;
  logic brk;

  // Our own drive is not timed, so a long zero we send is no break
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      low_cnt_r <= '0;
    end else if (line_r || drv_r) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != {CNT_W{1'b1}}) begin
      low_cnt_r <= low_cnt_r + CNT_W'(1);
    end
  end

  assign brk = (low_cnt_r >= P_BREAK_LOW);

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  rtop_state_e st_r;
  logic [CNT_W-1:0] cnt_r;
  logic [DATA_W-1:0] sh_r;
  logic [DATA_W-1:0] sh_nxt;
  logic [2:0] nbit_r;
  logic is_data_r;
  logic [DATA_W-1:0] cmd_r;
  logic rx_bit;

  // Short low decodes as one, long low as zero
  assign rx_bit = (low_cnt_r < P_DATA_SETUP);
  assign sh_nxt = {rx_bit, sh_r[DATA_W-1:1]};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      sh_r <= '0;
      nbit_r <= '0;
      is_data_r <= 1'h0;
      cmd_r <= '0;
      drv_r <= 1'h0;
      reg_req <= '0;
      break_seen <= 1'h0;
    end else begin
      reg_req.we <= 1'h0;
      reg_req.rd <= 1'h0;
      break_seen <= 1'h0;
      if (brk && st_r != ST_BREAK && st_r != ST_RECOVER) begin
        st_r <= ST_BREAK;
        nbit_r <= '0;
        is_data_r <= 1'h0;
        drv_r <= 1'h0;
        break_seen <= 1'h1;
      end else begin
        unique case (st_r)
          ST_IDLE: begin
            if (fall) begin
              st_r <= ST_LOW;
            end
          end
          ST_LOW: begin
            if (rise) begin
              st_r <= ST_IDLE;
              sh_r <= sh_nxt;
              nbit_r <= nbit_r + 3'h1;
              if (nbit_r == 3'(BITS_PER_BYTE - 1)) begin
                if (is_data_r) begin
                  is_data_r <= 1'h0;
                  // Writes to bad selects never reach the register file
                  reg_req.we <= rtop_writable(
                    cmd_r[REGISTER_SELECT_MSB:REGISTER_SELECT_LSB]);
                  reg_req.wdata <= sh_nxt;
                end else begin
                  cmd_r <= sh_nxt;
                  reg_req.addr <=
                    sh_nxt[REGISTER_SELECT_MSB:REGISTER_SELECT_LSB];
                  if (sh_nxt[CMD_DIR_BIT] == CMD_DIR_WRITE) begin
                    is_data_r <= 1'h1;
                  end else begin
                    reg_req.rd <= 1'h1;
                    st_r <= ST_TX_GAP;
                    cnt_r <= '0;
                  end
                end
              end
            end
          end
          ST_TX_GAP: begin
            // Host has released; keep high through stop hold
            cnt_r <= cnt_r + CNT_W'(1);
            if (cnt_r >= P_STOP_HOLD) begin
              sh_r <= reg_rdata;
              st_r <= ST_TX_BIT;
              cnt_r <= '0;
              drv_r <= 1'h1;
            end
          end
          ST_TX_BIT: begin
            cnt_r <= cnt_r + CNT_W'(1);
            // Low for start, kept low through hold only for a zero;
            // drive rose a cycle before the count, so stop one early
            drv_r <= (cnt_r < P_START_LOW - CNT_W'(1)) ||
              (!sh_r[0] && cnt_r < P_DATA_HOLD - CNT_W'(1));
            // Full bit cycle keeps the rate at or below the limit
            if (cnt_r >= P_BIT_CYCLE - CNT_W'(1)) begin
              cnt_r <= '0;
              sh_r <= {1'h0, sh_r[DATA_W-1:1]};
              nbit_r <= nbit_r + 3'h1;
              if (nbit_r == 3'(BITS_PER_BYTE - 1)) begin
                st_r <= ST_IDLE;
                drv_r <= 1'h0;
              end else begin
                drv_r <= 1'h1;
              end
            end
          end
          ST_BREAK: begin
            if (line_r) begin
              st_r <= ST_RECOVER;
              cnt_r <= '0;
            end
          end
          ST_RECOVER: begin
            // Line must stay high for the whole recovery time
            if (!line_r) begin
              st_r <= ST_BREAK;
            end else if (cnt_r >= P_BREAK_RECOVERY) begin
              st_r <= ST_IDLE;
            end else begin
              cnt_r <= cnt_r + CNT_W'(1);
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dq_out <= 1'h0;
      dq_oe_n <= 1'h1;
    end else begin
      dq_out <= 1'h0;
      dq_oe_n <= ~drv_r;
    end
  end

  assign command_byte_register = cmd_r;

endmodule

/* File: shared/rtop_pkg.sv */
// Constants, timing and carrier types of the return-to-one serial port.
// Assumes a 50 MHz system clock and an external pull-up on the data pin.
// Notes on behaviour
// - Pin is open-drain: pull low or release.
// - Command byte first, then data stored or returned.
// - Bit rate at most 333 bits per second.
// - Bytes travel least significant bit first.
// - Long low pulse is a break; receive restarts.
// - Each frame starts with transmitter pulling low.
// - Bit value valid by setup, held for hold.
// - Line high by stop setup, held through stop hold.
// - Command byte loaded only after eight bits.
// - Command bit 7: 0 reads, 1 writes.
// - Command bits 6 to 0 select the register.
// - Writes to invalid selects are dropped.
package rtop_pkg;

  // ---------------------------------------------------------------
  // Clock and widths
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int CNT_W = 20;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int BITS_PER_BYTE = 8;

  // ---------------------------------------------------------------
  // Command byte layout
  // ---------------------------------------------------------------
  localparam int CMD_DIR_BIT = 7;
  localparam int REGISTER_SELECT_MSB = 6;
  localparam int REGISTER_SELECT_LSB = 0;
  localparam logic CMD_DIR_READ = 1'h0;
  localparam logic CMD_DIR_WRITE = 1'h1;

  // ---------------------------------------------------------------
  // Writable register selects
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SEL_NAC_HIGH = 7'h03;
  localparam logic [ADDR_W-1:0] SEL_BATTERY_ID = 7'h04;
  localparam logic [ADDR_W-1:0] SEL_LAST_DISCHARGE = 7'h05;
  localparam logic [ADDR_W-1:0] SEL_THRESHOLD = 7'h0c;
  localparam logic [ADDR_W-1:0] SEL_RESET = 7'h39;

  // ---------------------------------------------------------------
  // Line timing, in microseconds or bits per second
  // ---------------------------------------------------------------
  localparam int MAX_BIT_RATE_BPS = 333;
  localparam int START_LOW_TIME_US = 100;
  localparam int DATA_SETUP_TIME_US = 500;
  localparam int DATA_HOLD_TIME_US = 1500;
  localparam int STOP_HOLD_TIME_US = 500;
  localparam int BREAK_LOW_TIME_US = 4000;
  localparam int BREAK_RECOVERY_TIME_US = 1000;

  // Cycle counts; the bit cycle is a least time and rounds up
  localparam int BIT_CYCLE_CYC =
    (CLK_HZ + MAX_BIT_RATE_BPS - 1) / MAX_BIT_RATE_BPS;
  localparam int START_LOW_CYC = START_LOW_TIME_US * CLK_PER_US;
  localparam int DATA_SETUP_CYC = DATA_SETUP_TIME_US * CLK_PER_US;
  localparam int DATA_HOLD_CYC = DATA_HOLD_TIME_US * CLK_PER_US;
  localparam int STOP_HOLD_CYC = STOP_HOLD_TIME_US * CLK_PER_US;
  localparam int BREAK_LOW_CYC = BREAK_LOW_TIME_US * CLK_PER_US;
  localparam int BREAK_RECOVERY_CYC = BREAK_RECOVERY_TIME_US * CLK_PER_US;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOW,
    ST_TX_GAP,
    ST_TX_BIT,
    ST_BREAK,
    ST_RECOVER
  } rtop_state_e;

  typedef struct packed {
    logic we;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rtop_reg_req_s;

  function automatic logic rtop_writable(input logic [ADDR_W-1:0] sel);
    return (sel == SEL_NAC_HIGH) || (sel == SEL_BATTERY_ID) ||
      (sel == SEL_LAST_DISCHARGE) || (sel == SEL_THRESHOLD) ||
      (sel == SEL_RESET);
  endfunction

endpackage

/* File: testbench/return_to_one_serial_port_test.sv */
// Self-checking bench: host model writes, reads and breaks the link.
// Assumes short timing parameters; the wire has a pull-up.
`timescale 1ns/1ns
module return_to_one_serial_port_test;
  import rtop_pkg::*;
  logic clk_sys, reset, dq_out, dq_oe_n, break_seen, host_pull, ok;
  logic [DATA_W-1:0] reg_rdata, command_byte_register, got, wd_seen;
  logic [ADDR_W-1:0] ad_seen;
  rtop_reg_req_s reg_req;
  wire logic dq_in = ~(host_pull | ~dq_oe_n);
  int err_count = 0, checks_done = 0, we_cnt = 0, brk_cnt = 0;
  logic [7:0] sels [5] = '{8'h03, 8'h04, 8'h05, 8'h0c, 8'h39};
  logic [7:0] rd_sels [2] = '{8'h17, 8'h2c};
  rtop_serial_port #(.P_BIT_CYCLE(20'h50), .P_START_LOW(20'h4),
    .P_DATA_SETUP(20'h14), .P_DATA_HOLD(20'h28), .P_STOP_HOLD(20'ha),
    .P_BREAK_LOW(20'hc8), .P_BREAK_RECOVERY(20'h1e)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .command_byte_register(command_byte_register),
    .break_seen(break_seen));
  rtop_host_model i_host (.clk_sys(clk_sys), .line_lvl(dq_in),
    .host_pull(host_pull));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (reg_req.we === 1'b1) begin
      we_cnt++;
      ad_seen = reg_req.addr;
      wd_seen = reg_req.wdata;
    end
    if (break_seen === 1'b1) brk_cnt++;
  end
  // Register file model: read data follows the select
  always @(posedge clk_sys) reg_rdata <= 8'h96 ^ {1'b0, reg_req.addr};
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic write(input logic [7:0] sel, input logic [7:0] d);
    i_host.send_byte(8'h80 | sel);
    check(command_byte_register, 8'h80 | sel);
    i_host.send_byte(d);
  endtask
  task automatic read(input logic [7:0] sel, output logic [7:0] v,
    output logic k);
    fork
      i_host.send_byte(sel);
      begin
        repeat (580) @(posedge clk_sys);
        i_host.recv_byte(v, k);
      end
    join
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_count++;
    results();
  end
  initial begin
    reset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (sels[i]) begin
      write(sels[i], ~sels[i]);
      check(8'(we_cnt), 8'(i + 1));
      check({1'b0, ad_seen}, sels[i]);
      check(wd_seen, ~sels[i]);
    end
    // Unwritable select: no write request may appear
    write(8'h01, 8'h5a);
    check(8'(we_cnt), 8'h05);
    foreach (rd_sels[i]) begin
      read(rd_sels[i], got, ok);
      check(command_byte_register, rd_sels[i]);
      check({7'h00, ok}, 8'h01);
      check(got, 8'h96 ^ rd_sels[i]);
      if (ok !== 1'b1) results();
      repeat (100) @(posedge clk_sys);
    end
    // Partial byte then break; the next command must start clean
    repeat (3) i_host.send_bit(1'b0);
    i_host.send_break();
    check(8'(brk_cnt), 8'h01);
    write(8'h04, 8'h3c);
    check({1'b0, ad_seen}, 8'h04);
    check(wd_seen, 8'h3c);
    // Reset in mid-run clears the command byte; next write still lands
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    check(command_byte_register, 8'h00);
    write(8'h05, 8'ha5);
    check({1'b0, ad_seen}, 8'h05);
    check(wd_seen, 8'ha5);
    results();
  end
endmodule

/* File: testbench/rtop_host_model.sv */
// Host end of the single-wire link: sends frames, times replies.
// Assumes the bench resolves the wire from both pull-downs.
`timescale 1ns/1ns
module rtop_host_model #(
  parameter int P_ONE = 5,
  parameter int P_ZERO = 40,
  parameter int P_CYC = 80,
  parameter int P_BRK = 220,
  parameter int P_REC = 40
) (
  // Clock and wire
  input wire logic clk_sys,
  input wire logic line_lvl,
  output logic host_pull
);
  initial host_pull = 1'b0;
  // Short low is one, long low zero; frame held to P_CYC
  task automatic send_bit(input logic b);
    @(posedge clk_sys) host_pull <= 1'b1;
    repeat (b ? P_ONE : P_ZERO) @(posedge clk_sys);
    host_pull <= 1'b0;
    repeat (P_CYC - (b ? P_ONE : P_ZERO)) @(posedge clk_sys);
  endtask
  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) send_bit(v[i]);
  endtask
  task automatic send_break();
    @(posedge clk_sys) host_pull <= 1'b1;
    repeat (P_BRK) @(posedge clk_sys);
    host_pull <= 1'b0;
    repeat (P_REC) @(posedge clk_sys);
  endtask
  // Bounded waits; ok drops if the device never answers
  task automatic recv_byte(output logic [7:0] v, output logic ok);
    int w;
    int n;
    ok = 1'b1;
    v = 8'h00;
    w = 0;
    while (line_lvl !== 1'b1 && w < 100) begin
      @(posedge clk_sys);
      w++;
    end
    for (int i = 0; i < 8; i++) begin
      w = 0;
      n = 0;
      while (line_lvl !== 1'b0 && w < 400) begin
        @(posedge clk_sys);
        w++;
      end
      while (line_lvl === 1'b0 && n < 100) begin
        @(posedge clk_sys);
        n++;
      end
      ok = ok & (w < 400) & (n < 100);
      v[i] = (n < 20);
    end
  endtask
endmodule

/* File: testbench/rtop_serial_port_checker.sv */
// Assertions on the serial port pins and register requests.
// Assumes the timing parameters handed on by the bind below.
`timescale 1ns/1ns
module rtop_serial_port_checker
  import rtop_pkg::*;
#(
  parameter logic [CNT_W-1:0] P_START_LOW = CNT_W'(START_LOW_CYC),
  parameter logic [CNT_W-1:0] P_DATA_HOLD = CNT_W'(DATA_HOLD_CYC)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pin and status
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe_n,
  input wire rtop_reg_req_s reg_req,
  input wire logic [DATA_W-1:0] command_byte_register,
  input wire logic break_seen
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Counts device low cycles so long frames need no long repetition
  logic [CNT_W-1:0] low_r;
  always_ff @(posedge clk_sys) begin
    low_r <= (reset || dq_oe_n) ? '0 : low_r + 1'b1;
  end
  pin_low_only_a: assert property (dq_out == 1'b0)
    else $error("data pin driven high");
  write_select_a: assert property (reg_req.we |->
    reg_req.addr inside {7'h03, 7'h04, 7'h05, 7'h0c, 7'h39})
    else $error("write to invalid select");
  write_cmd_a: assert property (reg_req.we |->
    command_byte_register == {1'b1, reg_req.addr})
    else $error("write without write command");
  read_cmd_a: assert property (reg_req.rd |->
    command_byte_register == {1'b0, reg_req.addr})
    else $error("read without read command");
  req_excl_a: assert property (!(reg_req.we && reg_req.rd))
    else $error("read and write together");
  read_gap_a: assert property (reg_req.rd |-> ##1 dq_oe_n[*8])
    else $error("reply starts without stop gap");
  frame_len_a: assert property ($rose(dq_oe_n) |->
    low_r == P_START_LOW || low_r == P_DATA_HOLD)
    else $error("device low pulse of wrong length");
  break_pulse_a: assert property (break_seen |=> !break_seen)
    else $error("break flag longer than one cycle");
  break_cause_a: assert property (break_seen |->
    !dq_in && !$past(dq_in, 8))
    else $error("break without long low");
  cover property (reg_req.we);
  cover property (reg_req.rd);
  cover property (break_seen);
endmodule
bind rtop_serial_port rtop_serial_port_checker #(
  .P_START_LOW(P_START_LOW), .P_DATA_HOLD(P_DATA_HOLD)
) i_chk (.clk_sys(clk_sys), .reset(reset), .dq_in(dq_in),
  .dq_out(dq_out), .dq_oe_n(dq_oe_n), .reg_req(reg_req),
  .command_byte_register(command_byte_register),
  .break_seen(break_seen));
